/* design/uie_regs.vh */
// Register offset, field positions, reset values and encodings for the IN endpoint control/status block.
// Assumes a 16-bit register reached over a plain address/strobe port.
`ifndef UIE_REGS_VH
`define UIE_REGS_VH

`define UIE_ADDR_W          12
`define UIE_CTRL_STAT_ADDR  12'h298
`define UIE_DATA_W          16

`define UIE_FILL_A_POS      0
`define UIE_FILL_B_POS      1
`define UIE_STARVE_POS      2
`define UIE_LOAD_DONE_POS   3
`define UIE_STARVE_CLR_POS  4
`define UIE_TOGGLE_RST_POS  5
`define UIE_DISCARD_POS     6
`define UIE_RATE_FB_POS     7
`define UIE_TIMED_POS       8
`define UIE_HALT_POS        9
`define UIE_AUTO_READY_POS  10

`define UIE_FILL_EMPTY      2'h0
`define UIE_FILL_ONE_DBL    2'h1
`define UIE_FILL_FULL       2'h3
`define UIE_FILL_RESET      2'h3

`define UIE_CFG_RESET       4'h0

`define UIE_HS_NONE         2'h0
`define UIE_HS_DATA         2'h1
`define UIE_HS_NAK          2'h2
`define UIE_HS_STALL        2'h3

`define UIE_PKT_W           11

`endif

/* design/uie_in_endpoint.v */
// Control and status logic for one non-zero USB IN endpoint.
// Assumes the protocol engine gives one-cycle pulses for IN token start and packet sent.
// What this block does
// - Flush with one set queued empties the transmit buffer
// - Flush with two sets queued discards only the older set
// - Flush updates buffer status exactly like a successful transmission
// - Rate-feedback select bit 1 picks rate feedback interrupt behaviour
// - Isochronous select bit 1 makes the endpoint isochronous
// - While halt bit set every IN transaction gets STALL
// - Auto ready marks a set loaded only at max packet or buffer size
// - Status 00 empty; double 01 one, 11 two; single 11 one
// - Underrun flag sticks at 1 until software clears it
// - Writing 1 to load-done registers one set; 0 does nothing
// - Writing 1 to underrun-clear resets the flag; 0 does nothing
// - Writing 1 to toggle-reset makes next data PID DATA0
// - Toggle reset also resets the transmit FIFO pointers
// - Isochronous IN token with empty buffer sets underrun flag
// - Status bits are 1 after reset, 0 when endpoint gets enabled
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "uie_regs.vh"

module uie_in_endpoint (
  input  wire                      clk_sys,
  input  wire                      reset,
  input  wire [`UIE_ADDR_W-1:0]    reg_addr,
  input  wire [`UIE_DATA_W-1:0]    reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [`UIE_DATA_W-1:0]    reg_rdata,
  input  wire                      ep_enable,
  input  wire                      double_buffer,
  input  wire                      continuous_mode,
  input  wire [`UIE_PKT_W-1:0]     max_packet_size,
  input  wire [`UIE_PKT_W-1:0]     buffer_size,
  input  wire                      fifo_byte_wr,
  input  wire                      in_token_start,
  input  wire                      pkt_sent_ok,
  output reg  [1:0]                handshake_sel,
  output reg                       handshake_valid,
  output reg                       data_pid_odd,
  output reg                       fifo_ptr_reset,
  output reg                       rate_feedback_select,
  output reg                       timed_stream_mode,
  output reg                       tx_busy
);

  reg [1:0]             fill_q;
  reg [1:0]             fill_d;
  reg                   starve_q;
  reg                   toggle_q;
  reg                   rate_fb_q;
  reg                   timed_q;
  reg                   halt_q;
  reg                   auto_ready_q;
  reg                   enable_q;
  reg [`UIE_PKT_W-1:0]  load_cnt_q;

  wire reg_hit  = (reg_addr == `UIE_CTRL_STAT_ADDR);
  wire wr_hit   = reg_wr & reg_hit;
  // reserved bits are simply ignored on write
  wire cmd_load    = wr_hit & reg_wdata[`UIE_LOAD_DONE_POS];
  wire cmd_stclr   = wr_hit & reg_wdata[`UIE_STARVE_CLR_POS];
  wire cmd_toggle  = wr_hit & reg_wdata[`UIE_TOGGLE_RST_POS];
  wire cmd_discard = wr_hit & reg_wdata[`UIE_DISCARD_POS];

  wire fill_empty = (fill_q == `UIE_FILL_EMPTY);
  wire [`UIE_PKT_W-1:0] auto_target = continuous_mode ? buffer_size : max_packet_size;
  wire [`UIE_PKT_W-1:0] load_cnt_inc = load_cnt_q + {{(`UIE_PKT_W-1){1'b0}}, 1'b1};
  wire auto_load = auto_ready_q & fifo_byte_wr & (load_cnt_inc == auto_target);
  wire add_set   = cmd_load | auto_load;
  // Transmit success and flush take the same path
  wire sent_ok   = pkt_sent_ok & ~fill_empty;
  wire drop_set  = sent_ok | (cmd_discard & ~fill_empty);
  wire en_rise   = ep_enable & ~enable_q;

  // Buffer status counter in documented encoding
  always @* begin
    fill_d = fill_q;
    if (add_set & ~drop_set) begin
      if (fill_empty)
        fill_d = double_buffer ? `UIE_FILL_ONE_DBL : `UIE_FILL_FULL;
      else
        fill_d = `UIE_FILL_FULL;
    end else if (drop_set & ~add_set) begin
      if (double_buffer & (fill_q == `UIE_FILL_FULL))
        fill_d = `UIE_FILL_ONE_DBL;
      else
        fill_d = `UIE_FILL_EMPTY;
    end
  end

  // Next values, one decoder per register
  reg                   starve_d;
  reg                   toggle_d;
  reg                   rate_fb_d;
  reg                   timed_d;
  reg                   halt_d;
  reg                   auto_ready_d;
  reg [`UIE_PKT_W-1:0]  load_cnt_d;
  reg [1:0]             hs_sel_d;
  reg                   tx_busy_d;
  reg                   pid_odd_d;
  reg [`UIE_DATA_W-1:0] rd_word_d;

  // Every write to the register reloads all four settings
  always @* begin
    rate_fb_d    = rate_fb_q;
    timed_d      = timed_q;
    halt_d       = halt_q;
    auto_ready_d = auto_ready_q;
    if (wr_hit) begin
      rate_fb_d    = reg_wdata[`UIE_RATE_FB_POS];
      timed_d      = reg_wdata[`UIE_TIMED_POS];
      halt_d       = reg_wdata[`UIE_HALT_POS];
      auto_ready_d = reg_wdata[`UIE_AUTO_READY_POS];
    end
  end

  // Underrun detection wins over a clear in the same cycle
  always @* begin
    starve_d = starve_q;
    if (timed_q & in_token_start & fill_empty)
      starve_d = 1'b1;
    else if (cmd_stclr)
      starve_d = 1'b0;
  end

  // Pointer reset wins over a flip from a finished send
  always @* begin
    toggle_d = toggle_q;
    if (cmd_toggle)
      toggle_d = 1'b0;
    else if (sent_ok & ~halt_q)
      toggle_d = ~toggle_q;
  end

  // Byte count restarts on each registered set or pointer reset
  always @* begin
    load_cnt_d = load_cnt_q;
    if (cmd_toggle | add_set)
      load_cnt_d = {`UIE_PKT_W{1'b0}};
    else if (fifo_byte_wr)
      load_cnt_d = load_cnt_inc;
  end

  // Halt outranks an empty buffer; rate feedback uses the same path
  always @* begin
    hs_sel_d = handshake_sel;
    if (in_token_start) begin
      if (halt_q)
        hs_sel_d = `UIE_HS_STALL;
      else if (fill_empty)
        hs_sel_d = `UIE_HS_NAK;
      else
        hs_sel_d = `UIE_HS_DATA;
    end
  end

  // Undefined if a flush lands mid-packet, firmware avoids it
  always @* begin
    tx_busy_d = tx_busy;
    if (in_token_start & ~halt_q & ~fill_empty)
      tx_busy_d = 1'b1;
    else if (pkt_sent_ok)
      tx_busy_d = 1'b0;
  end

  // A pointer reset shows DATA0 at once, in the same cycle as the toggle register, not one cycle behind it
  always @* begin
    pid_odd_d = toggle_q;
    if (cmd_toggle)
      pid_odd_d = 1'b0;
  end

  // Command and reserved bits always read 0
  always @* begin
    rd_word_d = {`UIE_DATA_W{1'b0}};
    if (reg_rd & reg_hit) begin
      rd_word_d[`UIE_FILL_A_POS]     = fill_q[0];
      rd_word_d[`UIE_FILL_B_POS]     = fill_q[1];
      rd_word_d[`UIE_STARVE_POS]     = starve_q;
      rd_word_d[`UIE_RATE_FB_POS]    = rate_fb_q;
      rd_word_d[`UIE_TIMED_POS]      = timed_q;
      rd_word_d[`UIE_HALT_POS]       = halt_q;
      rd_word_d[`UIE_AUTO_READY_POS] = auto_ready_q;
    end
  end

  // Enabling the endpoint overrides any status update
  always @(posedge clk_sys) begin
    if (reset) begin
      fill_q <= `UIE_FILL_RESET;
    end else if (en_rise) begin
      fill_q <= `UIE_FILL_EMPTY;
    end else begin
      fill_q <= fill_d;
    end
  end

  // Idles low like a disabled endpoint, so no false edge after reset
  always @(posedge clk_sys) begin
    if (reset) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= ep_enable;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      rate_fb_q <= 1'b0;
    end else begin
      rate_fb_q <= rate_fb_d;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      timed_q <= 1'b0;
    end else begin
      timed_q <= timed_d;
    end
  end

  // Held until firmware writes it again
  always @(posedge clk_sys) begin
    if (reset) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= halt_d;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      auto_ready_q <= 1'b0;
    end else begin
      auto_ready_q <= auto_ready_d;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      starve_q <= 1'b0;
    end else begin
      starve_q <= starve_d;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      load_cnt_q <= {`UIE_PKT_W{1'b0}};
    end else begin
      load_cnt_q <= load_cnt_d;
    end
  end

  // Answer flag stands one cycle after each token
  always @(posedge clk_sys) begin
    if (reset) begin
      handshake_valid <= 1'b0;
    end else begin
      handshake_valid <= in_token_start;
    end
  end

  // Handshake code holds until the next token
  always @(posedge clk_sys) begin
    if (reset) begin
      handshake_sel <= `UIE_HS_NONE;
    end else begin
      handshake_sel <= hs_sel_d;
    end
  end

  // Busy from a DATA answer until the send completes
  always @(posedge clk_sys) begin
    if (reset) begin
      tx_busy <= 1'b0;
    end else begin
      tx_busy <= tx_busy_d;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      data_pid_odd <= 1'b0;
    end else begin
      data_pid_odd <= pid_odd_d;
    end
  end

  // One-cycle pulse, the FIFO pointers restart from it
  always @(posedge clk_sys) begin
    if (reset) begin
      fifo_ptr_reset <= 1'b0;
    end else begin
      fifo_ptr_reset <= cmd_toggle;
    end
  end

  // Copies lag the setting by one cycle
  always @(posedge clk_sys) begin
    if (reset) begin
      rate_feedback_select <= 1'b0;
    end else begin
      rate_feedback_select <= rate_fb_q;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      timed_stream_mode <= 1'b0;
    end else begin
      timed_stream_mode <= timed_q;
    end
  end

  // Read data stand for one cycle only
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= {`UIE_DATA_W{1'b0}};
    end else begin
      reg_rdata <= rd_word_d;
    end
  end

endmodule
`default_nettype wire

/* test/uie_in_endpoint_properties.sv */
// Port-level checks for the IN endpoint control/status block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "uie_regs.vh"
module uie_in_endpoint_properties (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        in_token_start,
  input wire logic [1:0]  handshake_sel,
  input wire logic        handshake_valid,
  input wire logic        data_pid_odd,
  input wire logic        fifo_ptr_reset,
  input wire logic        rate_feedback_select,
  input wire logic        timed_stream_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic hit;
  logic halt_q;
  assign hit = reg_wr && reg_addr == `UIE_CTRL_STAT_ADDR;
  // Halt is not on a port, so mirror it
  always @(posedge clk_sys) halt_q <= reset ? 1'h0 : hit ? reg_wdata[9] : halt_q;
  a_token_answer: assert property (in_token_start |=> handshake_valid ##1 !handshake_valid)
    else $error("token answer wrong");
  a_halt_stall: assert property (in_token_start && halt_q |=> handshake_sel == `UIE_HS_STALL)
    else $error("no stall while halted");
  a_cmd_read_zero: assert property (reg_rd |=> reg_rdata[6:3] == 4'h0 && reg_rdata[15:11] == 5'h0)
    else $error("command bits read back");
  a_fill_code: assert property (reg_rd |=> reg_rdata[1:0] != 2'h2)
    else $error("unused fill code");
  a_ptr_reset: assert property (hit && reg_wdata[5] |=> fifo_ptr_reset && !data_pid_odd)
    else $error("toggle reset missed");
  a_no_ptr_reset: assert property (!(hit && reg_wdata[5]) |=> !fifo_ptr_reset)
    else $error("spurious pointer reset");
  a_rate_fb: assert property (hit |=> ##1 rate_feedback_select == $past(reg_wdata[7], 2))
    else $error("rate feedback select wrong");
  a_iso_mode: assert property (hit |=> ##1 timed_stream_mode == $past(reg_wdata[8], 2))
    else $error("iso select wrong");
endmodule
bind uie_in_endpoint uie_in_endpoint_properties i_props (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .in_token_start, .handshake_sel, .handshake_valid, .data_pid_odd, .fifo_ptr_reset,
  .rate_feedback_select, .timed_stream_mode);
`default_nettype wire

/* test/uie_host_model.sv */
// Host model: IN tokens on request, sent pulse after a DATA answer.
// Assumes the bench asks for a token only when no send is pending.
`timescale 1ns/10ps
`default_nettype none
`include "uie_regs.vh"
module uie_host_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic       handshake_valid,
  input  wire logic [1:0] handshake_sel,
  output var  logic       in_token_start,
  output var  logic       pkt_sent_ok
);
  logic [2:0] wait_q;
  always @(posedge clk_sys) begin
    in_token_start <= go && !reset;
    pkt_sent_ok <= !reset && wait_q == 3'h1;
    if (reset)
      wait_q <= 3'h0;
    else if (handshake_valid && handshake_sel == `UIE_HS_DATA)
      wait_q <= slow ? 3'h6 : 3'h1;
    else if (wait_q != 3'h0)
      wait_q <= wait_q - 3'h1;
  end
endmodule
`default_nettype wire

/* test/uie_in_endpoint_tb.sv */
// Bench: buffer, flush, underrun, stall and auto-ready cases plus random config.
// Assumes the host model answers DATA handshakes.
`timescale 1ns/10ps
`default_nettype none
`include "uie_regs.vh"
module uie_in_endpoint_tb;
  logic clk_sys = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, ep_enable = 1'h0, double_buffer = 1'h1;
  logic continuous_mode = 1'h0, fifo_byte_wr = 1'h0, go = 1'h0, slow = 1'h0, tgl = 1'h0;
  logic in_token_start, pkt_sent_ok, handshake_valid, data_pid_odd, fifo_ptr_reset;
  logic rate_feedback_select, timed_stream_mode, tx_busy;
  logic [1:0] handshake_sel;
  logic [11:0] reg_addr = `UIE_CTRL_STAT_ADDR;
  logic [15:0] reg_wdata = 16'h0, cfg = 16'h0, v, reg_rdata;
  logic [10:0] max_packet_size = 11'h4, buffer_size = 11'h8;
  logic [31:0] seed = 32'hf4d73258;
  int error_cnt = 0, samples_checked = 0, n = 0;
  uie_in_endpoint i_dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ep_enable,
    .double_buffer, .continuous_mode, .max_packet_size, .buffer_size, .fifo_byte_wr, .in_token_start,
    .pkt_sent_ok, .handshake_sel, .handshake_valid, .data_pid_odd, .fifo_ptr_reset, .rate_feedback_select,
    .timed_stream_mode, .tx_busy);
  uie_host_model i_host (.clk_sys, .reset, .go, .slow, .handshake_valid, .handshake_sel, .in_token_start,
    .pkt_sent_ok);
  always #50 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [1:0] fill(input int k);
    return k == 0 ? 2'h0 : (double_buffer && k == 1) ? 2'h1 : 2'h3;
  endfunction
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    reg_wr <= 1'h1;
    reg_wdata <= d | cfg;
    @(posedge clk_sys) reg_wr <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic rd;
    reg_rd <= 1'h1;
    @(posedge clk_sys) reg_rd <= 1'h0;
    #1 v = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic st;
    rd;
    chk("fill", v[1:0], fill(n));
  endtask
  task automatic byt(input int k);
    if (k > 0) begin
      fifo_byte_wr <= 1'h1;
      repeat (k) @(posedge clk_sys);
      fifo_byte_wr <= 1'h0;
    end
    @(posedge clk_sys);
  endtask
  task automatic tok(input logic [1:0] hs);
    go <= 1'h1;
    @(posedge clk_sys) go <= 1'h0;
    for (int i = 0; i < 4 && handshake_valid !== 1'h1; i++) @(posedge clk_sys) #1;
    chk("hs", {handshake_valid, handshake_sel}, {1'h1, hs});
    chk("busy", tx_busy, hs == `UIE_HS_DATA);
    if (handshake_valid !== 1'h1) tally_and_finish;
    if (hs == `UIE_HS_DATA) begin
      n--;
      tgl = ~tgl;
    end
    repeat (10) @(posedge clk_sys);
    chk("busy", tx_busy, 1'h0);
    chk("pid", data_pid_odd, tgl);
    st;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'h0;
    rd;
    chk("rst", v, 16'h3);
    reg_addr <= 12'h29a;
    rd;
    chk("unmapped", v, 16'h0);
    reg_addr <= `UIE_CTRL_STAT_ADDR;
    ep_enable <= 1'h1;
    wr(16'h0);
    st;
    repeat (6) begin
      seed = xs(seed);
      cfg = {7'h0, seed[1:0], 7'h0};
      slow <= seed[2];
      max_packet_size <= {8'h0, seed[5:3]} + 11'h1;
      buffer_size <= {8'h0, seed[8:6]} + 11'h1;
      wr(16'h0);
      rd;
      chk("cfg", v[10:7], cfg[10:7]);
      chk("mode", {timed_stream_mode, rate_feedback_select}, cfg[8:7]);
    end
    cfg = 16'h0;
    repeat (2) begin
      wr(16'h8);
      n++;
      st;
    end
    repeat (3) begin
      wr(16'h40);
      n = n > 0 ? n - 1 : 0;
      st;
      chk("pid", data_pid_odd, 1'h0);
    end
    double_buffer <= 1'h0;
    wr(16'h8);
    n = 1;
    st;
    tok(`UIE_HS_DATA);
    cfg = 16'h100;
    wr(16'h0);
    tok(`UIE_HS_NAK);
    repeat (2) begin
      rd;
      chk("starve", v[2], 1'h1);
    end
    wr(16'h10);
    rd;
    chk("starve", v[2], 1'h0);
    wr(16'h20);
    tgl = 1'h0;
    chk("pid", data_pid_odd, 1'h0);
    cfg = 16'h200;
    wr(16'h0);
    tok(`UIE_HS_STALL);
    cfg = 16'h400;
    wr(16'h0);
    tok(`UIE_HS_NAK);
    for (int m = 0; m < 2; m++) begin
      continuous_mode <= m[0];
      @(posedge clk_sys);
      byt(int'(m ? buffer_size : max_packet_size) - 1);
      st;
      byt(1);
      n = 1;
      st;
      wr(16'h40);
      n = 0;
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
